// File: include/psd_defines.svh
/*
 Timing and field constants for the synthesizer divider block.
 Assumes inclusion by its bare name from rtl and include paths.
*/
`ifndef PSD_DEFINES_SVH
`define PSD_DEFINES_SVH
`define PSD_SWALLOW_W 5
`define PSD_PROGRAM_W 9
`define PSD_REF_W 8
`define PSD_PRESC_HI 6'h21
`define PSD_PRESC_LO 6'h20
`define PSD_PROGRAM_MIN 9'h01F
`endif

// File: include/psd_pkg.sv
/*
 Types for the synthesizer divider block.
 Assumes nothing of its surroundings.
*/
`default_nettype none
package psd_pkg;
   typedef enum logic [0:0] {PSD_DIV33, PSD_DIV32} psd_mod_e;
endpackage
`default_nettype wire

// File: rtl/psd_dividers.sv
/*
 Feedback divider (32/33 prescaler with swallow and program counters),
 reference divider and phase-frequency detector of an integer-N synthesizer.
 Assumes osc_en and xtal_en are one-cycle enables marking oscillator and
 crystal edges, already synchronous to clk; divisors come from configuration.
*/
`timescale 1ns/1ns
`default_nettype none
`include "psd_defines.svh"
// Behaviour
// [R01] Prescaler plus 5-bit swallow, 9-bit program counters
// [R02] Divide 33 until swallow done, then 32
// [R03] Ratio is swallow plus 32 times program
// [R04] Reference divides crystal by 1 to 256
// [R05] Detector compares divided signals, outputs error
// [R06] Locked output equals ratio times reference
// [R08] Detector is phase-frequency type
// [R09] Divisors reload only at cycle start
module psd_dividers
   import psd_pkg::*;
#(
   parameter int SW_W = `PSD_SWALLOW_W,
   parameter int PG_W = `PSD_PROGRAM_W,
   parameter int RF_W = `PSD_REF_W
) (
   input wire logic clk, // System clock, 125 MHz
   input wire logic reset, // Asynchronous reset, active high
   input wire logic osc_en, // One pulse per oscillator cycle
   input wire logic xtal_en, // One pulse per crystal cycle
   input wire logic [SW_W-1:0] cfg_swallow, // Swallow value 0..31
   input wire logic [PG_W-1:0] cfg_program, // Program value 31..511
   input wire logic [RF_W-1:0] cfg_ref, // Reference divisor, 0 means 256
   output logic fb_pulse, // Divided oscillator, one pulse per N
   output logic ref_pulse, // Divided crystal, one pulse per R
   output logic pump_up, // Raise oscillator frequency
   output logic pump_down // Lower oscillator frequency
);
   logic [5:0] pre_cnt, next_pre_cnt;
   logic [SW_W-1:0] sw_cnt, next_sw_cnt, sw_val, next_sw_val;
   logic [PG_W-1:0] pg_cnt, next_pg_cnt, pg_val, next_pg_val;
   psd_mod_e modsel, next_modsel;
   logic [RF_W-1:0] rf_cnt, next_rf_cnt, rf_val, next_rf_val;
   logic next_fb, next_ref, next_up, next_dn;
   logic pre_done, cycle_end;

   // Prescaler output edge ends each 33 or 32 oscillator cycles
   always_comb begin
      pre_done = osc_en && (pre_cnt == ((modsel == PSD_DIV33) ?
                 `PSD_PRESC_HI - 6'h01 : `PSD_PRESC_LO - 6'h01)); // R02
      cycle_end = pre_done && (pg_cnt == pg_val - {{(PG_W-1){1'b0}}, 1'b1});
      next_pre_cnt = pre_cnt;
      next_sw_cnt = sw_cnt;
      next_pg_cnt = pg_cnt;
      next_modsel = modsel;
      next_sw_val = sw_val;
      next_pg_val = pg_val;
      next_fb = 1'b0;
      if (osc_en) begin
         next_pre_cnt = pre_done ? 6'h00 : pre_cnt + 6'h01;
      end
      if (cycle_end) begin
         // New divisors take effect only here, never mid-cycle
         next_sw_val = cfg_swallow; // R09
         next_pg_val = (cfg_program < `PSD_PROGRAM_MIN) ? `PSD_PROGRAM_MIN : cfg_program; // R09
         next_sw_cnt = '0;
         next_pg_cnt = '0;
         next_modsel = (cfg_swallow == '0) ? PSD_DIV32 : PSD_DIV33; // R02
         next_fb = 1'b1; // R03
      end else if (pre_done) begin
         next_pg_cnt = pg_cnt + {{(PG_W-1){1'b0}}, 1'b1}; // R01
         if (modsel == PSD_DIV33) begin
            next_sw_cnt = sw_cnt + {{(SW_W-1){1'b0}}, 1'b1}; // R01
            if (sw_cnt + {{(SW_W-1){1'b0}}, 1'b1} == sw_val) begin
               next_modsel = PSD_DIV32; // R02
            end
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pre_cnt <= 6'h00;
         sw_cnt <= '0;
         pg_cnt <= '0;
         sw_val <= '0;
         pg_val <= `PSD_PROGRAM_MIN;
         modsel <= PSD_DIV32;
         fb_pulse <= 1'b0;
      end else begin
         pre_cnt <= next_pre_cnt;
         sw_cnt <= next_sw_cnt;
         pg_cnt <= next_pg_cnt;
         sw_val <= next_sw_val;
         pg_val <= next_pg_val;
         modsel <= next_modsel;
         fb_pulse <= next_fb;
      end
   end

   // Reference divider; zero encodes 256 so all eight bits are usable
   always_comb begin
      next_rf_cnt = rf_cnt;
      next_rf_val = rf_val;
      next_ref = 1'b0;
      if (xtal_en) begin
         if (rf_cnt == rf_val - {{(RF_W-1){1'b0}}, 1'b1}) begin
            next_rf_cnt = '0;
            next_rf_val = cfg_ref; // R09
            next_ref = 1'b1; // R04
         end else begin
            next_rf_cnt = rf_cnt + {{(RF_W-1){1'b0}}, 1'b1}; // R04
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rf_cnt <= '0;
         rf_val <= {{(RF_W-1){1'b0}}, 1'b1};
         ref_pulse <= 1'b0;
      end else begin
         rf_cnt <= next_rf_cnt;
         rf_val <= next_rf_val;
         ref_pulse <= next_ref;
      end
   end

   // Classic two-flop detector: both high clears both, giving frequency sense
   always_comb begin
      next_up = pump_up | ref_pulse; // R05
      next_dn = pump_down | fb_pulse; // R05
      if (next_up && next_dn) begin
         next_up = 1'b0; // R08
         next_dn = 1'b0; // R08
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pump_up <= 1'b0;
         pump_down <= 1'b0;
      end else begin
         pump_up <= next_up;
         pump_down <= next_dn;
      end
   end

   // Independent edge counts per divided cycle, read only by the checks below
   localparam int NT_W = SW_W + PG_W;
   logic [NT_W-1:0] osc_seen, next_osc_seen, n_total;
   logic [RF_W:0] xtal_seen, next_xtal_seen, r_total;

   always_comb begin
      // Factor 32 is the low modulus, a shift by the swallow width
      n_total = {{PG_W{1'b0}}, sw_val} + {pg_val, {SW_W{1'b0}}}; // R03
      r_total = (rf_val == '0) ? {1'b1, {RF_W{1'b0}}} : {1'b0, rf_val}; // R04
      next_osc_seen = osc_seen;
      next_xtal_seen = xtal_seen;
      if (cycle_end) begin
         next_osc_seen = '0;
      end else if (osc_en) begin
         next_osc_seen = osc_seen + {{(NT_W-1){1'b0}}, 1'b1};
      end
      if (next_ref) begin
         next_xtal_seen = '0;
      end else if (xtal_en) begin
         next_xtal_seen = xtal_seen + {{RF_W{1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         osc_seen <= '0;
         xtal_seen <= '0;
      end else begin
         osc_seen <= next_osc_seen;
         xtal_seen <= next_xtal_seen;
      end
   end

   // Locked loop yields fb rate equal ref rate, so output is N times reference
   // A lone leading pulse must keep its pump on until the other edge arrives
   sequence s_ref_leads;
      ref_pulse && !fb_pulse && !pump_down;
   endsequence
   sequence s_fb_leads;
      fb_pulse && !ref_pulse && !pump_up;
   endsequence
   sequence s_no_fb;
      !fb_pulse;
   endsequence
   sequence s_no_ref;
      !ref_pulse;
   endsequence

   chk_fb_spacing: assert property (@(posedge clk) disable iff (reset) // R03
      fb_pulse |=> !fb_pulse) else $error("feedback pulses back to back");
   chk_ref_pulse: assert property (@(posedge clk) disable iff (reset) // R04
      ref_pulse |-> $past(xtal_en)) else $error("reference pulse without crystal edge");
   chk_pump_excl: assert property (@(posedge clk) disable iff (reset) // R08
      !(pump_up && pump_down)) else $error("both pumps active");
   chk_up_set: assert property (@(posedge clk) disable iff (reset) // R05
      (ref_pulse && !fb_pulse && !pump_down) |=> pump_up) else $error("up not set");
   chk_dn_set: assert property (@(posedge clk) disable iff (reset) // R05
      (fb_pulse && !ref_pulse && !pump_up) |=> pump_down) else $error("down not set");
   chk_mod_switch: assert property (@(posedge clk) disable iff (reset) // R02
      (modsel == PSD_DIV32 && !cycle_end) |=> modsel == PSD_DIV32)
      else $error("modulus returned to 33 mid cycle");
   chk_swallow_cap: assert property (@(posedge clk) disable iff (reset) // R01
      modsel == PSD_DIV33 |-> sw_cnt < sw_val) else $error("swallow overran");
   chk_reload_hold: assert property (@(posedge clk) disable iff (reset) // R09
      !cycle_end |=> $stable(pg_val)) else $error("divisor changed mid cycle");
   chk_ratio_count: assert property (@(posedge clk) disable iff (reset) // R03
      cycle_end |-> (osc_seen + {{(NT_W-1){1'b0}}, 1'b1} == n_total))
      else $error("feedback cycle length differs from ratio");
   chk_ref_count: assert property (@(posedge clk) disable iff (reset) // R04
      next_ref |-> (xtal_seen + {{RF_W{1'b0}}, 1'b1} == r_total))
      else $error("reference cycle length differs from divisor");
   chk_fb_follows: assert property (@(posedge clk) disable iff (reset) // R03
      cycle_end |=> fb_pulse) else $error("feedback pulse missing at cycle end");
   chk_fb_origin: assert property (@(posedge clk) disable iff (reset) // R03
      fb_pulse |-> $past(cycle_end)) else $error("feedback pulse without cycle end");
   chk_mod_start: assert property (@(posedge clk) disable iff (reset) // R02
      cycle_end |=> ((modsel == PSD_DIV33) == (sw_val != '0)))
      else $error("wrong modulus at cycle start");
   chk_pre_wrap: assert property (@(posedge clk) disable iff (reset) // R02
      pre_done |=> (pre_cnt == 6'h00)) else $error("prescaler did not wrap");
   chk_ref_reload: assert property (@(posedge clk) disable iff (reset) // R09
      !next_ref |=> $stable(rf_val)) else $error("reference divisor changed mid cycle");
   chk_up_release: assert property (@(posedge clk) disable iff (reset) // R08
      (pump_up && fb_pulse) |=> !pump_up) else $error("up not cancelled by feedback");
   chk_dn_release: assert property (@(posedge clk) disable iff (reset) // R08
      (pump_down && ref_pulse) |=> !pump_down) else $error("down not cancelled by reference");
   chk_up_stands: assert property (@(posedge clk) disable iff (reset) // R05
      s_ref_leads ##1 s_no_fb |=> pump_up) else $error("up dropped before feedback");
   chk_dn_stands: assert property (@(posedge clk) disable iff (reset) // R05
      s_fb_leads ##1 s_no_ref |=> pump_down) else $error("down dropped before reference");
endmodule
`default_nettype wire

// File: testbench/psd_dividers_bench.sv
/* Bench for the divider block. Assumes the edge model. */
`timescale 1ns/1ns
`default_nettype none
module psd_dividers_bench;
   logic clk, reset, osc_on, xtal_on, osc_en, xtal_en, fb_pulse, ref_pulse, pump_up, pump_down;
   logic [4:0] cfg_swallow, nsw;
   logic [8:0] cfg_program, npg;
   logic [7:0] cfg_ref, nrf;
   int miscompares = 0;
   int n_compared = 0;
   int n;
   psd_osc_model osc (.clk(clk), .reset(reset), .osc_on(osc_on), .xtal_on(xtal_on),
      .osc_en(osc_en), .xtal_en(xtal_en));
   psd_dividers dut (.clk(clk), .reset(reset), .osc_en(osc_en), .xtal_en(xtal_en),
      .cfg_swallow(cfg_swallow), .cfg_program(cfg_program), .cfg_ref(cfg_ref),
      .fb_pulse(fb_pulse), .ref_pulse(ref_pulse), .pump_up(pump_up), .pump_down(pump_down));
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
      n_compared++;
      if (s !== e) begin
         $display("BAD %s expected %0d seen %0d", nm, e, s);
         miscompares++;
      end
   endtask
   task automatic close_out();
      if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic hit(input bit sel);
      do @(negedge clk); while (!(sel ? ref_pulse : fb_pulse));
   endtask
   // Counts one period; new divisors land mid-period, so it must keep the old ones
   task automatic period(input bit sel, input bit ch);
      n = sel ? xtal_en : osc_en;
      do begin
         @(posedge clk);
         if (ch && n == 1) begin
            cfg_swallow <= nsw;
            cfg_program <= npg;
            cfg_ref <= nrf;
         end
         @(negedge clk);
         if (!(sel ? ref_pulse : fb_pulse)) n += sel ? xtal_en : osc_en;
      end while (!(sel ? ref_pulse : fb_pulse));
   endtask
   task automatic t_fb();
      logic [4:0] sw[5] = '{5'h05, 5'h1F, 5'h03, 5'h00, 5'h00};
      logic [8:0] pg[5] = '{9'h028, 9'h1FF, 9'h005, 9'h01F, 9'h01F};
      int ex[5] = '{1285, 16383, 995, 992, 992};
      int prev = 992;
      hit(1'b0);
      for (int i = 0; i < 5; i++) begin
         nsw = sw[i];
         npg = pg[i];
         period(1'b0, 1'b1);
         chk("fb", 16'(prev), 16'(n));
         prev = ex[i];
      end
   endtask
   task automatic t_ref();
      logic [7:0] rf[5] = '{8'h00, 8'h03, 8'hFF, 8'h01, 8'h01};
      int ex[5] = '{256, 3, 255, 1, 1};
      int prev = 4;
      hit(1'b1);
      for (int i = 0; i < 5; i++) begin
         nrf = rf[i];
         period(1'b1, 1'b1);
         chk("ref", 16'(prev), 16'(n));
         prev = ex[i];
      end
   endtask
   task automatic t_pfd();
      @(posedge clk) osc_on <= 1'b0;
      repeat (2) hit(1'b1);
      @(negedge clk);
      chk("up", 16'h1, {15'h0, pump_up});
      chk("dn", 16'h0, {15'h0, pump_down});
      @(posedge clk) osc_on <= 1'b1;
      xtal_on <= 1'b0;
      hit(1'b0);
      @(negedge clk);
      chk("up", 16'h0, {15'h0, pump_up});
      hit(1'b0);
      @(negedge clk);
      chk("dn", 16'h1, {15'h0, pump_down});
   endtask
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      repeat (40000) @(posedge clk);
      miscompares++;
      close_out();
   end
   initial begin
      {reset, osc_on, xtal_on} = 3'h4;
      {cfg_swallow, nsw, cfg_program, npg} = {5'h00, 5'h00, 9'h01F, 9'h01F};
      {cfg_ref, nrf} = {8'h04, 8'h04};
      repeat (5) @(posedge clk);
      {reset, osc_on, xtal_on} <= 3'h3;
      t_fb();
      t_ref();
      t_pfd();
      close_out();
   end
endmodule
`default_nettype wire

// File: testbench/psd_osc_model.sv
/* Oscillator and crystal edge model. Assumes one clk domain. */
`timescale 1ns/1ns
`default_nettype none
module psd_osc_model (
   input wire logic clk, // Clock
   input wire logic reset, // Reset
   input wire logic osc_on, // Oscillator runs
   input wire logic xtal_on, // Crystal runs
   output logic osc_en, // Fast edge train
   output logic xtal_en // Slow edge train
);
   logic ph;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ph <= 1'b0;
         osc_en <= 1'b0;
         xtal_en <= 1'b0;
      end else begin
         ph <= ~ph;
         osc_en <= osc_on;
         xtal_en <= xtal_on & ph;
      end
   end
endmodule
`default_nettype wire
